/* File: hw/ipm_pkg.sv */
// Package with constants, types and pattern layout for the pattern-based I2C master
package ipm_pkg;
   // ----------------------------------------------------------------
   // Pattern memory layout
   // ----------------------------------------------------------------
   localparam int          PAT_DEPTH     = 92;
   localparam int          PAT_AW        = 7;
   localparam logic [6:0]  PAT_LAST      = 7'h5b;
   localparam logic [6:0]  PAT_FIRST     = 7'h00;
   localparam logic [7:0]  PAT_IDLE      = 8'h1f;  // SCL and all four SDA streams released
   // Byte fields: bit0 SCL, bits1..4 SDA streams, bit5 ack check, bit6 compare, bit7 end
   localparam int          BIT_SCL       = 0;
   localparam int          BIT_SDA0      = 1;
   localparam int          BIT_ACK       = 5;
   localparam int          BIT_CMP       = 6;
   localparam int          BIT_END       = 7;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int          MCLK_HZ       = 50_000_000;
   localparam int          PCLK_HZ       = 1_000_000;  // Pattern step rate
   localparam int          PCLK_DIV      = MCLK_HZ / PCLK_HZ / 2;
   localparam logic [7:0]  PCLK_DIV_LAST = 8'(PCLK_DIV - 1);
   localparam logic [7:0]  CNT_ZERO      = 8'h00;
   localparam int          DGL_NS        = 200;         // Trigger deglitch time
   localparam int          DGL_CYC       = (DGL_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [7:0]  DGL_LAST      = 8'(DGL_CYC - 1);
   localparam logic [7:0]  REF_INIT      = 8'h00;
   typedef enum logic [1:0] {
      IPM_IDLE = 2'b00,
      IPM_RUN  = 2'b01,
      IPM_HALT = 2'b10
   } ipm_state_e;
endpackage

/* File: hw/ipm_pat_if.sv */
// Interface carrying one pattern step from the link domain
`timescale 1ns/10ps
interface ipm_pat_if;
   logic [7:0] pat_byte;
   logic       step_tgl;
   modport src (output pat_byte, output step_tgl);
   modport dst (input  pat_byte, input  step_tgl);
endinterface

/* File: hw/ipm_deglitch.sv */
// Counter deglitch filter for the trigger input
`timescale 1ns/10ps
module ipm_deglitch
   import ipm_pkg::*;
(
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic ce,
   input  wire logic din,
   output logic      dout
);
   logic [2:0] sync_ff, nxt_sync;
   logic [7:0] cnt_ff,  nxt_cnt;
   logic       out_ff,  nxt_out;
   // ----------------------------------------------------------------
   // Three-stage sync then count stable samples
   // ----------------------------------------------------------------
   always_comb begin
      nxt_sync = {sync_ff[1:0], din};
      nxt_cnt  = cnt_ff;
      nxt_out  = out_ff;
      if (sync_ff[2] != sync_ff[1] || sync_ff[1] == out_ff) begin
         nxt_cnt = CNT_ZERO;                 // Any bounce restarts the wait
      end else if (cnt_ff == DGL_LAST) begin
         nxt_out = sync_ff[2];
         nxt_cnt = CNT_ZERO;
      end else begin
         nxt_cnt = cnt_ff + 8'h01;
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync_ff <= 3'b000;
         cnt_ff  <= CNT_ZERO;
         out_ff  <= 1'b0;
      end else if (ce) begin
         sync_ff <= nxt_sync;
         cnt_ff  <= nxt_cnt;
         out_ff  <= nxt_out;
      end
   end
   assign dout = out_ff;
endmodule

/* File: hw/ipm_master.sv */
// Top: pattern-replay I2C master with acknowledge check and read compare
`timescale 1ns/10ps
module ipm_master
   import ipm_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       resetn,
   input  wire logic       clk_en,
   input  wire logic       pclk,
   input  wire logic       trigger,
   input  wire logic       stream_select_low,
   input  wire logic       stream_select_high,
   input  wire logic       wrap_mode,
   input  wire logic       is_read,
   input  wire logic [7:0] ref_data,
   input  wire logic       pat_we,
   input  wire logic [6:0] pat_waddr,
   input  wire logic [7:0] pat_wdata,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            scl_o,
   output logic            scl_oe,
   output logic            sda_o,
   output logic            sda_oe,
   output logic            pattern_clock_out,
   output logic            busy,
   output logic            nack_halt,
   output logic            compare_result_flop
);
   // ----------------------------------------------------------------
   // Reset release and pattern clock generator (mclk domain)
   // ----------------------------------------------------------------
   logic [1:0] rst_ff;
   logic       rst_n;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) rst_ff <= 2'b00;
      else         rst_ff <= {rst_ff[0], 1'b1};
   end
   assign rst_n = rst_ff[1];

   logic [7:0] pattern_clock_counter_ff, nxt_pcc;
   logic       pcg_ff, nxt_pcg;
   logic       run_ff;
   // Gate only lets the divided clock out while a command runs
   always_comb begin
      nxt_pcc = pattern_clock_counter_ff + 8'h01;
      nxt_pcg = pcg_ff;
      if (pattern_clock_counter_ff == PCLK_DIV_LAST) begin
         nxt_pcc = CNT_ZERO;
         nxt_pcg = ~pcg_ff & run_ff;
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pattern_clock_counter_ff <= CNT_ZERO;
         pcg_ff                   <= 1'b0;
      end else if (clk_en) begin
         pattern_clock_counter_ff <= nxt_pcc;
         pcg_ff                   <= nxt_pcg;
      end
   end

   logic trig_clean;
   ipm_deglitch u_dgl (
      .mclk (mclk),
      .rst_n(rst_n),
      .ce   (clk_en),
      .din  (trigger),
      .dout (trig_clean)
   );

   // ----------------------------------------------------------------
   // Link domain: pattern memory and sequencer on pclk
   // ----------------------------------------------------------------
   logic [7:0] pat_mem [PAT_DEPTH];
   logic [6:0] addr_ff, nxt_addr;
   logic [1:0] lrun_sync;
   logic       lrst_n;
   ipm_pat_if  pif ();
   logic [7:0] pbyte_ff, nxt_pbyte;
   logic       ptgl_ff;
   logic [1:0] lrst_ff;
   // Pattern load is synchronous to pclk; host must hold it idle while running
   always_ff @(posedge pclk) begin
      if (pat_we) pat_mem[pat_waddr] <= pat_wdata;
   end
   always_ff @(posedge pclk or negedge rst_n) begin
      if (!rst_n) lrst_ff <= 2'b00;
      else        lrst_ff <= {lrst_ff[0], 1'b1};
   end
   assign lrst_n = lrst_ff[1];
   // Run level crosses in through two flops
   always_ff @(posedge pclk or negedge lrst_n) begin
      if (!lrst_n) lrun_sync <= 2'b00;
      else         lrun_sync <= {lrun_sync[0], run_ff};
   end
   always_comb begin
      nxt_addr  = addr_ff;
      nxt_pbyte = pbyte_ff;
      if (!lrun_sync[1]) begin
         nxt_addr  = PAT_FIRST;
         nxt_pbyte = PAT_IDLE;
      end else begin
         nxt_pbyte = pat_mem[addr_ff];
         if (addr_ff == PAT_LAST) begin
            nxt_addr = wrap_mode ? PAT_FIRST : addr_ff;
         end else begin
            nxt_addr = addr_ff + 7'h01;
         end
      end
   end
   always_ff @(posedge pclk or negedge lrst_n) begin
      if (!lrst_n) begin
         addr_ff  <= PAT_FIRST;
         pbyte_ff <= PAT_IDLE;
         ptgl_ff  <= 1'b0;
      end else begin
         addr_ff  <= nxt_addr;
         pbyte_ff <= nxt_pbyte;
         ptgl_ff  <= ~ptgl_ff;
      end
   end
   assign pif.pat_byte = pbyte_ff;
   assign pif.step_tgl = ptgl_ff;

   // ----------------------------------------------------------------
   // Crossing back: toggle synchroniser, byte sampled once it settles
   // ----------------------------------------------------------------
   logic [2:0] tgl_sync;
   logic [7:0] sb1_ff, sb2_ff;
   logic       step;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tgl_sync <= 3'b000;
         sb1_ff   <= PAT_IDLE;
         sb2_ff   <= PAT_IDLE;
      end else if (clk_en) begin
         tgl_sync <= {tgl_sync[1:0], pif.step_tgl};
         sb1_ff   <= pif.pat_byte;
         sb2_ff   <= sb1_ff;
      end
   end
   assign step = tgl_sync[2] ^ tgl_sync[1];

   // SDA from outside syncs through three flops; scl_i is not used
   logic [2:0] sda_sync;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) sda_sync <= 3'b111;
      else if (clk_en) sda_sync <= {sda_sync[1:0], sda_i};
   end

   function automatic logic mux4(input logic [3:0] s, input logic hi, input logic lo);
      mux4 = s[{hi, lo}];
   endfunction

   // ----------------------------------------------------------------
   // Control: start, ack check, compare
   // ----------------------------------------------------------------
   ipm_state_e st_ff, nxt_st;
   logic       trig_d_ff, nxt_trig_d;
   logic [7:0] reference_shift_register_ff, nxt_ref;
   logic       nxt_cmp, nxt_nack, nxt_scl, nxt_sda, nxt_run, nack_ff, scl_ff, sda_ff;
   logic       ack_bit, cmp_bit;
   assign ack_bit = sb2_ff[BIT_ACK];
   assign cmp_bit = sb2_ff[BIT_CMP];
   always_comb begin
      nxt_st     = st_ff;
      nxt_trig_d = trig_clean;
      nxt_ref    = reference_shift_register_ff;
      nxt_cmp    = compare_result_flop;
      nxt_nack   = nack_ff;
      nxt_run    = run_ff;
      nxt_scl    = scl_ff;
      nxt_sda    = sda_ff;
      case (st_ff)
         IPM_IDLE, IPM_HALT: begin
            nxt_scl = 1'b1;
            nxt_sda = 1'b1;
            if (trig_clean && !trig_d_ff) begin
               nxt_st   = IPM_RUN;
               nxt_run  = 1'b1;
               nxt_nack = 1'b0;
               if (is_read) begin
                  nxt_ref = ref_data;
                  nxt_cmp = 1'b1;
               end
            end
         end
         IPM_RUN: begin
            if (step) begin
               nxt_scl = sb2_ff[BIT_SCL];
               nxt_sda = mux4(sb2_ff[BIT_SDA0 +: 4], stream_select_high, stream_select_low);
               if (ack_bit && sda_sync[2] && sda_sync[1]) begin
                  nxt_st   = IPM_HALT;
                  nxt_run  = 1'b0;
                  nxt_nack = 1'b1;
                  nxt_scl  = 1'b1;
                  nxt_sda  = 1'b1;
               end else if (sb2_ff[BIT_END] && !wrap_mode) begin
                  nxt_st  = IPM_IDLE;
                  nxt_run = 1'b0;
               end
               if (cmp_bit) begin
                  if (sda_sync[2] != reference_shift_register_ff[7])
                     nxt_cmp = 1'b0;
                  nxt_ref = {reference_shift_register_ff[6:0], 1'b0};
               end
            end
         end
         default: begin
            nxt_st  = IPM_IDLE;
            nxt_run = 1'b0;
         end
      endcase
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff                       <= IPM_IDLE;
         trig_d_ff                   <= 1'b0;
         reference_shift_register_ff <= REF_INIT;
         compare_result_flop         <= 1'b0;
         nack_ff                     <= 1'b0;
         run_ff                      <= 1'b0;
         scl_ff                      <= 1'b1;
         sda_ff                      <= 1'b1;
      end else if (clk_en) begin
         st_ff                       <= nxt_st;
         trig_d_ff                   <= nxt_trig_d;
         reference_shift_register_ff <= nxt_ref;
         compare_result_flop         <= nxt_cmp;
         nack_ff                     <= nxt_nack;
         run_ff                      <= nxt_run;
         scl_ff                      <= nxt_scl;
         sda_ff                      <= nxt_sda;
      end
   end
   // Open drain: enable is the inverse of the driven level
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         scl_o  <= 1'b0;
         scl_oe <= 1'b0;
         sda_o  <= 1'b0;
         sda_oe <= 1'b0;
         pattern_clock_out <= 1'b0;
         busy      <= 1'b0;
         nack_halt <= 1'b0;
      end else if (clk_en) begin
         scl_o  <= 1'b0;
         scl_oe <= ~nxt_scl;
         sda_o  <= 1'b0;
         sda_oe <= ~nxt_sda;
         pattern_clock_out <= nxt_pcg;
         busy      <= nxt_run;
         nack_halt <= nxt_nack;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_nack_stops;
      @(posedge mclk) disable iff (!rst_n)
      (clk_en && st_ff == IPM_RUN && step && ack_bit && sda_sync[2] && sda_sync[1])
         |=> (st_ff == IPM_HALT && !run_ff);
   endproperty
   a_nack_stops: assert property (p_nack_stops) else $error("nack did not halt");
   property p_halt_releases;
      @(posedge mclk) disable iff (!rst_n)
      (st_ff == IPM_HALT && clk_en) |=> (!sda_oe && !scl_oe);
   endproperty
   a_halt_releases: assert property (p_halt_releases) else $error("lines held in halt");
   property p_mismatch_clears;
      @(posedge mclk) disable iff (!rst_n)
      (clk_en && st_ff == IPM_RUN && step && cmp_bit
         && sda_sync[2] != reference_shift_register_ff[7]) |=> !compare_result_flop;
   endproperty
   a_mismatch_clears: assert property (p_mismatch_clears) else $error("mismatch lost");
   property p_ref_shift;
      @(posedge mclk) disable iff (!rst_n)
      (clk_en && st_ff == IPM_RUN && step && cmp_bit)
         |=> reference_shift_register_ff[7] == $past(reference_shift_register_ff[6]);
   endproperty
   a_ref_shift: assert property (p_ref_shift) else $error("reference not shifted");
   property p_result_holds;
      @(posedge mclk) disable iff (!rst_n)
      (st_ff != IPM_RUN && !(trig_clean && !trig_d_ff)) |=> $stable(compare_result_flop);
   endproperty
   a_result_holds: assert property (p_result_holds) else $error("result changed idle");
   property p_read_start;
      @(posedge mclk) disable iff (!rst_n)
      (clk_en && st_ff == IPM_IDLE && trig_clean && !trig_d_ff && is_read)
         |=> (compare_result_flop && st_ff == IPM_RUN);
   endproperty
   a_read_start: assert property (p_read_start) else $error("read start wrong");
   property p_gate_off;
      @(posedge mclk) disable iff (!rst_n)
      (!run_ff && clk_en) [*3] |=> $stable(pattern_clock_out) || !pattern_clock_out;
   endproperty
   a_gate_off: assert property (p_gate_off) else $error("pattern clock leaks");
   property p_sda_mux;
      @(posedge mclk) disable iff (!rst_n)
      (clk_en && st_ff == IPM_RUN && step && !ack_bit)
         |=> sda_oe == !mux4($past(sb2_ff[BIT_SDA0 +: 4]), stream_select_high, stream_select_low);
   endproperty
   a_sda_mux: assert property (p_sda_mux) else $error("sda stream wrong");
   c_nack:  cover property (@(posedge mclk) disable iff (!rst_n) st_ff == IPM_HALT);
   c_match: cover property (@(posedge mclk) disable iff (!rst_n)
                            st_ff == IPM_RUN ##1 st_ff == IPM_IDLE && compare_result_flop);
   c_write: cover property (@(posedge mclk) disable iff (!rst_n)
                            !is_read && st_ff == IPM_RUN ##1 st_ff == IPM_IDLE);
endmodule

/* File: testbench/ipm_slave_model.sv */
// Behavioural I2C slave that answers the pattern master
`timescale 1ns/10ps
module ipm_slave_model #(
   parameter logic [6:0] DEV_ADDR = 7'h2a  // Arbitrary bus address
) (
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic [7:0] tx_byte,
   output logic            sda_pull
);
   logic       act   = 1'b0;
   logic       first = 1'b0;
   logic       rd    = 1'b0;
   logic [3:0] bitc  = 4'h0;
   logic [7:0] shreg = 8'h00;
   logic [7:0] rx_q[$];
   initial sda_pull = 1'b0;

   // --------------------------------------------------------------
   // Framing
   // --------------------------------------------------------------
   // Start and stop are SDA edges while SCL is high
   always @(negedge sda) if (scl === 1'b1) begin
      act = 1'b1;
      first = 1'b1;
      bitc = 4'h0;
   end
   always @(posedge sda) if (scl === 1'b1) act = 1'b0;

   // Sample on rising SCL; the ninth clock closes the byte
   always @(posedge scl) if (act) begin
      if (bitc == 4'h8) begin
         bitc = 4'h0;
         if (!first && !rd) rx_q.push_back(shreg);
         if (!first && rd && sda) act = 1'b0;  // Master said no more
         first = 1'b0;
      end else begin
         shreg = {shreg[6:0], sda};
         bitc = bitc + 4'h1;
      end
   end

   // Change the drive only on falling SCL, so no false start or stop appears
   always @(negedge scl) begin
      if (!act)
         sda_pull = 1'b0;
      else if (bitc == 4'h8) begin
         if (first) rd = shreg[0];
         sda_pull = first ? (shreg[7:1] == DEV_ADDR) : !rd;
         if (first && !sda_pull) act = 1'b0;
      end else
         sda_pull = rd && !first && !tx_byte[7 - bitc];
   end
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the pattern-replay I2C master
`timescale 1ns/10ps
module tb_top;
   import ipm_pkg::*;
   localparam logic [6:0] DEV_ADDR = 7'h2a;  // Arbitrary bus address
   logic       mclk = 1'b0, pclk = 1'b0, resetn = 1'b0, trigger = 1'b0;
   logic       wrap_mode = 1'b0, is_read = 1'b0, pat_we = 1'b0, ce = 1'b1;
   logic [7:0] ref_data = 8'h00, pat_wdata = 8'h00, tx_byte = 8'h00;
   logic [6:0] pat_waddr = 7'h00;
   logic [1:0] sel = 2'h0;
   logic [7:0] pat [0:91];
   logic [7:0] wdat [0:1];
   wire        scl, sda, scl_o, sda_o, scl_oe, sda_oe, pco, busy, nack_halt, res, slv_pull;
   int         err_total = 0, checks = 0, cyc = 0, seed = 32'h4684, np, bcyc, tgl;

   // Open-drain lines with pull-ups
   assign scl = (scl_oe === 1'b1) ? 1'b0 : 1'b1;
   assign sda = (sda_oe === 1'b1 || slv_pull === 1'b1) ? 1'b0 : 1'b1;

   always #10 mclk = ~mclk;
   // Pattern clock rises at 80 ns plus whole periods, never on a rising mclk edge
   always #80 pclk = ~pclk;

   ipm_master dut (.mclk(mclk), .resetn(resetn), .clk_en(ce), .pclk(pclk),
      .trigger(trigger), .stream_select_low(sel[0]), .stream_select_high(sel[1]),
      .wrap_mode(wrap_mode), .is_read(is_read), .ref_data(ref_data), .pat_we(pat_we),
      .pat_waddr(pat_waddr), .pat_wdata(pat_wdata), .scl_i(scl), .sda_i(sda),
      .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe),
      .pattern_clock_out(pco), .busy(busy), .nack_halt(nack_halt),
      .compare_result_flop(res));
   ipm_slave_model #(.DEV_ADDR(DEV_ADDR)) slv (.scl(scl), .sda(sda), .tx_byte(tx_byte),
      .sda_pull(slv_pull));

   // --------------------------------------------------------------
   // Bookkeeping
   // --------------------------------------------------------------
   // Cycle budget, busy duration and gate clock toggles
   always @(posedge mclk) begin
      cyc++;
      if (busy === 1'b1) bcyc++;
      if (cyc == 60000) begin
         err_total++;
         report_and_stop();
      end
   end
   always @(pco) tgl++;

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // --------------------------------------------------------------
   // Pattern building: three steps a bit so SDA moves only under SCL low
   // --------------------------------------------------------------
   task automatic put(input logic c, input logic d, input logic a, input logic m);
      logic [3:0] s;
      s = {4{~d}};  // Unselected streams carry the inverse
      s[sel] = d;
      pat[np] = {1'b0, m, a, s, c};
      np++;
   endtask
   task automatic put_bit(input logic d, input logic a, input logic m);
      put(1'b0, d, 1'b0, 1'b0);
      put(1'b1, d, a, m);
      put(1'b0, d, 1'b0, 1'b0);
   endtask
   task automatic put_byte(input logic [7:0] b, input logic rd);
      for (int i = 7; i >= 0; i--) put_bit(b[i] | rd, 1'b0, rd);
      put_bit(1'b1, !rd, 1'b0);  // Reads end with a master nack
   endtask
   task automatic build(input logic [6:0] adr, input logic rd, input int nb);
      np = 0;
      put(1'b1, 1'b1, 1'b0, 1'b0);
      put(1'b1, 1'b0, 1'b0, 1'b0);
      put(1'b0, 1'b0, 1'b0, 1'b0);
      put_byte({adr, rd}, 1'b0);
      for (int i = 0; i < nb; i++) put_byte(rd ? 8'h00 : wdat[i], rd);
      put(1'b0, 1'b0, 1'b0, 1'b0);
      put(1'b1, 1'b0, 1'b0, 1'b0);
      put(1'b1, 1'b1, 1'b0, 1'b0);
      pat[np - 1][BIT_END] = 1'b1;
   endtask

   // Pattern memory is written from the pattern clock side while idle
   task automatic load();
      for (int i = 0; i < np; i++) begin
         @(posedge pclk);
         #1;
         pat_we = 1'b1;
         pat_waddr = 7'(i);
         pat_wdata = pat[i];
      end
      @(posedge pclk);
      #1;
      pat_we = 1'b0;
   endtask

   task automatic pulse(input int n);
      @(posedge mclk);
      #1;
      trigger = 1'b1;
      repeat (n) @(posedge mclk);
      #1;
      trigger = 1'b0;
   endtask

   // Trigger held past the filter, optional retrigger while running
   task automatic run(input logic again);
      bcyc = 0;
      slv.rx_q.delete();
      pulse(20);
      if (again) begin
         repeat (15) @(posedge mclk);
         pulse(20);
      end
      for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge mclk);
      #1;
   endtask

   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial begin
      repeat (3) @(posedge mclk);
      #1;
      resetn = 1'b1;
      repeat (10) @(posedge mclk);
      // Writes through every stream select, the last of one byte
      for (int k = 0; k < 4; k++) begin
         sel = 2'(k);
         wdat[0] = 8'($random(seed));
         wdat[1] = 8'($random(seed));
         build(DEV_ADDR, 1'b0, (k == 3) ? 1 : 2);
         load();
         run(k == 0);
         if (k == 0) repeat (40) @(posedge mclk);
         check(busy, 8'h00, "idle after command");
         check(8'(slv.rx_q.size()), (k == 3) ? 8'h01 : 8'h02, "byte count");
         check(slv.rx_q[0], wdat[0], "first byte");
         if (k < 3) check(slv.rx_q[1], wdat[1], "second byte");
         check(nack_halt, 8'h00, "no halt");
         check({scl_oe, sda_oe}, 8'h00, "lines released");
         check({scl_o, sda_o}, 8'h00, "pins only sink");
      end
      // Wrong address: the slave stays silent, master must give up early
      build(DEV_ADDR ^ 7'h01, 1'b0, 2);
      load();
      run(1'b0);
      check(nack_halt, 8'h01, "halt on nack");
      check(8'(slv.rx_q.size()), 8'h00, "nothing written");
      check(8'(bcyc < 400), 8'h01, "stopped early");
      // Reads: equal reference, one flipped bit, equal again, then a write
      for (int k = 0; k < 4; k++) begin
         tx_byte = 8'($random(seed));
         ref_data = (k == 1) ? tx_byte ^ (8'h01 << 3'($random(seed))) : tx_byte;
         is_read = (k != 3);
         build(DEV_ADDR, is_read, 1);
         load();
         run(1'b0);
         check(res, (k == 1) ? 8'h00 : 8'h01, "compare result");
         check(nack_halt, 8'h00, "halt cleared by start");
         check(slv.rx_q.size() == 0 || k == 3, 8'h01, "read owns bus");
      end
      check(res, 8'h01, "result kept over write");
      // Short trigger pulses must not pass the filter
      pulse(5);
      repeat (40) @(posedge mclk);
      check(busy, 8'h00, "glitch ignored");
      // Full-length idle pattern: stop at its end, or wrap and run on
      #1 sel = 2'h0;
      np = 0;
      for (int i = 0; i < PAT_DEPTH; i++) put(1'b1, 1'b1, 1'b0, 1'b0);
      pat[PAT_LAST][BIT_END] = 1'b1;
      load();
      for (int w = 0; w < 2; w++) begin
         #1 wrap_mode = w[0];
         pulse(20);
         repeat (85) @(posedge pclk);
         check(busy, 8'h01, "still stepping");
         repeat (20) @(posedge pclk);
         check(busy, 8'(w), "end option");
      end
      // Enable low must freeze the gate clock and the running command
      @(posedge mclk);
      #1;
      ce = 1'b0;
      tgl = 0;
      repeat (100) @(posedge mclk);
      #1;
      check(8'(tgl), 8'h00, "frozen by enable");
      check(busy, 8'h01, "busy kept while frozen");
      ce = 1'b1;
      tgl = 0;
      repeat (500) @(posedge mclk);
      #1;
      check(8'(tgl), 8'h14, "gate clock toggles");
      // Reset in mid-run releases the bus at once
      resetn = 1'b0;
      repeat (3) @(posedge mclk);
      check({busy, scl_oe, sda_oe}, 8'h00, "quiet in reset");
      #1;
      resetn = 1'b1;
      repeat (10) @(posedge mclk);
      report_and_stop();
   end
endmodule
